/* hw/pee_params.svh */
// Purpose: Offsets, field positions and reset values of the event export.
// Assumes: Included by every file that needs them.
// Notes: Definitions only.
`ifndef PEE_PARAMS_SVH
`define PEE_PARAMS_SVH
`define PEE_EVT_W 52
`define PEE_FLAG_W 7
`define PEE_ADDR_CTRL 8'h00
`define PEE_ADDR_SWINC 8'h04
`define PEE_ADDR_STATUS 8'h08
`define PEE_ADDR_EVLO 8'h0C
`define PEE_ADDR_EVHI 8'h10
`define PEE_CTRL_RESET 4'h1
`define PEE_CTRL_EXPORT 0
`define PEE_CTRL_MEDIA 1
`define PEE_CTRL_DEPRES 2
`define PEE_CTRL_MP 3
`define PEE_FPS_SAT 27
`define PEE_FPS_IDC 7
`define PEE_B_MEM 1
`define PEE_B_REN 8
`define PEE_B_FLOW 10
`define PEE_B_RET 15
`define PEE_B_UNAL 16
`define PEE_B_MISP 17
`define PEE_B_PBR 18
`define PEE_B_BC 19
`define PEE_B_COH 22
`define PEE_B_STALL 24
`define PEE_B_PIPE 32
`define PEE_B_FPREN 35
`define PEE_B_SIMDREN 37
`define PEE_B_MSTALL 39
`define PEE_B_CLKOFF 46
`define PEE_B_BAR 48
`endif

/* hw/pee_pkg.sv */
// Purpose: Types shared by the event export modules.
// Assumes: Nothing beyond the params header.
// Notes: Nothing is imported; users write pee_pkg::name.
package pee_pkg;
  typedef struct packed {
    logic sw_inc;
    logic [6:0] mem;
    logic [1:0] ren_cnt;
    logic [4:0] flow;
    logic ret;
    logic unal;
    logic misp;
    logic pred_br;
    logic [2:0] bytecode;
    logic coh_miss;
    logic coh_hit;
    logic [7:0] stall;
    logic [2:0] pipe;
    logic [1:0] fp_cnt;
    logic [1:0] simd_cnt;
    logic [6:0] mstall;
    logic [1:0] clkoff;
    logic [3:0] barrier;
  } pee_raw_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WR = 2'b01,
    PH_RD = 2'b10
  } pee_phase_t;
endpackage

/* hw/pee_evt_if.sv */
// Purpose: Carries raw core events to the mapper and the bus back.
// Assumes: One clock domain.
// Notes: Purely combinational link.
`timescale 1ns/1ns
`include "pee_params.svh"
interface pee_evt_if;
  pee_pkg::pee_raw_t raw;
  logic [`PEE_EVT_W-1:0] bus;
  modport mapper (input raw, output bus);
  modport user (output raw, input bus);
endinterface

/* hw/pee_event_map.sv */
// Purpose: Places each raw core event on its fixed event bus bit.
// Assumes: Raw inputs are one-cycle pulses and counts of 0 to 2.
// Notes: Combinational; the top registers the result.
`timescale 1ns/1ns
`include "pee_params.svh"
module pee_event_map
(
  pee_evt_if.mapper ev
);
  // A count of three is not a legal rename figure, so it reports none.
  function automatic logic [1:0] pee_cnt_code(input logic [1:0] c);
    pee_cnt_code = (c == 2'h1) ? 2'h1 : ((c == 2'h2) ? 2'h2 : 2'h0);
  endfunction
  wire [7:0] lo_events = {ev.raw.mem, ev.raw.sw_inc};
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_lo
      assign ev.bus[i] = lo_events[i];
    end
  endgenerate
  assign ev.bus[`PEE_B_REN+1:`PEE_B_REN] =
    pee_cnt_code(ev.raw.ren_cnt);
  assign ev.bus[`PEE_B_FLOW+4:`PEE_B_FLOW] = ev.raw.flow;
  assign ev.bus[`PEE_B_RET] = ev.raw.ret;
  assign ev.bus[`PEE_B_UNAL] = ev.raw.unal;
  assign ev.bus[`PEE_B_MISP] = ev.raw.misp;
  assign ev.bus[`PEE_B_PBR] = ev.raw.pred_br;
  assign ev.bus[`PEE_B_BC+2:`PEE_B_BC] = ev.raw.bytecode;
  assign ev.bus[`PEE_B_COH] = ev.raw.coh_miss;
  assign ev.bus[`PEE_B_COH+1] = ev.raw.coh_hit;
  assign ev.bus[`PEE_B_STALL+7:`PEE_B_STALL] = ev.raw.stall;
  assign ev.bus[`PEE_B_PIPE+2:`PEE_B_PIPE] = ev.raw.pipe;
  assign ev.bus[`PEE_B_FPREN+1:`PEE_B_FPREN] =
    pee_cnt_code(ev.raw.fp_cnt);
  assign ev.bus[`PEE_B_SIMDREN+1:`PEE_B_SIMDREN] =
    pee_cnt_code(ev.raw.simd_cnt);
  assign ev.bus[`PEE_B_MSTALL+6:`PEE_B_MSTALL] = ev.raw.mstall;
  assign ev.bus[`PEE_B_CLKOFF+1:`PEE_B_CLKOFF] = ev.raw.clkoff;
  assign ev.bus[`PEE_B_BAR+3:`PEE_B_BAR] = ev.raw.barrier;
endmodule // pee_event_map

/* hw/pee_top.sv */
// Purpose: Exports core performance events, flags and state to outside.
// Assumes: All core inputs are synchronous to hclk; events are pulses.
// Notes: Registers reached over AHB-Lite, zero wait states, always OKAY.
`timescale 1ns/1ns
`include "pee_params.svh"
module pee_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic core_sw_inc,
  input wire logic [6:0] core_mem_evt,
  input wire logic [1:0] core_ren_cnt,
  input wire logic [4:0] core_flow_evt,
  input wire logic core_func_ret,
  input wire logic core_unaligned,
  input wire logic core_mispredict,
  input wire logic core_pred_branch,
  input wire logic [2:0] core_bytecode_evt,
  input wire logic core_coh_miss,
  input wire logic core_coh_hit,
  input wire logic [7:0] core_stall_evt,
  input wire logic [2:0] core_pipe_evt,
  input wire logic [1:0] core_fp_ren_cnt,
  input wire logic [1:0] core_simd_ren_cnt,
  input wire logic [6:0] core_mem_stall_evt,
  input wire logic [1:0] core_clkoff_evt,
  input wire logic [3:0] core_barrier_evt,
  input wire logic [31:0] fp_status_control_reg,
  input wire logic core_secure,
  input wire logic core_privileged,
  input wire logic core_ovf_irq,
  output logic [`PEE_EVT_W-1:0] perf_event_bus,
  output logic [`PEE_FLAG_W-1:0] vector_unit_flags,
  output logic perf_monitor_irq,
  output logic secure_state_out,
  output logic privileged_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [3:0] ctrl;
  logic sw_inc_req;
  pee_pkg::pee_phase_t phase;
  logic [7:0] wr_addr;
  pee_evt_if evt ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire bus_take = hsel && hready && htrans[1];
  wire [7:0] a_off = haddr[7:0];
  wire a_mapped = (haddr[31:8] == 24'h00_0000);
  wire hit_ctrl = a_mapped && (a_off == `PEE_ADDR_CTRL);
  wire hit_swinc = a_mapped && (a_off == `PEE_ADDR_SWINC);
  wire hit_status = a_mapped && (a_off == `PEE_ADDR_STATUS);
  wire hit_evlo = a_mapped && (a_off == `PEE_ADDR_EVLO);
  wire hit_evhi = a_mapped && (a_off == `PEE_ADDR_EVHI);
  wire wr_now = (phase == pee_pkg::PH_WR);
  wire wr_ctrl = wr_now && (wr_addr == `PEE_ADDR_CTRL);
  wire wr_swinc = wr_now && (wr_addr == `PEE_ADDR_SWINC) && hwdata[0];

  wire export_en = ctrl[`PEE_CTRL_EXPORT];
  wire media_eng = ctrl[`PEE_CTRL_MEDIA];
  wire de_present = ctrl[`PEE_CTRL_DEPRES];
  wire mp_config = ctrl[`PEE_CTRL_MP];

  wire [31:0] status_word = {
    22'h00_0000,
    perf_monitor_irq,
    privileged_mode_out,
    secure_state_out,
    vector_unit_flags
  };
  wire [31:0] rd_word =
    hit_ctrl ? {28'h000_0000, ctrl} :
    hit_status ? status_word :
    hit_evlo ? perf_event_bus[31:0] :
    hit_evhi ? {12'h000, perf_event_bus[`PEE_EVT_W-1:32]} :
    32'h0000_0000;
  wire [pee_pkg::PH_RD:0] unused_sel = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Raw event gathering.

  // Coherent linefill events only exist when the core sits in a cluster.
  assign evt.raw.sw_inc = core_sw_inc || sw_inc_req;
  assign evt.raw.mem = core_mem_evt;
  assign evt.raw.ren_cnt = core_ren_cnt;
  assign evt.raw.flow = core_flow_evt;
  assign evt.raw.ret = core_func_ret;
  assign evt.raw.unal = core_unaligned;
  assign evt.raw.misp = core_mispredict;
  assign evt.raw.pred_br = core_pred_branch;
  assign evt.raw.bytecode = core_bytecode_evt;
  assign evt.raw.coh_miss = core_coh_miss && mp_config;
  assign evt.raw.coh_hit = core_coh_hit && mp_config;
  assign evt.raw.stall = core_stall_evt;
  assign evt.raw.pipe = core_pipe_evt;
  assign evt.raw.fp_cnt = core_fp_ren_cnt;
  assign evt.raw.simd_cnt = core_simd_ren_cnt;
  assign evt.raw.mstall = core_mem_stall_evt;
  assign evt.raw.clkoff = core_clkoff_evt;
  assign evt.raw.barrier = core_barrier_evt;

  pee_event_map u_map
  (
    .ev(evt.mapper)
  );

  wire [`PEE_EVT_W-1:0] next_event_bus =
    export_en ? evt.bus : {`PEE_EVT_W{1'b0}};

  // Without a data engine the flags do not exist and read as zero.
  wire [`PEE_FLAG_W-1:0] next_flags = de_present ? {
    media_eng && fp_status_control_reg[`PEE_FPS_SAT],
    fp_status_control_reg[`PEE_FPS_IDC],
    fp_status_control_reg[4:0]
  } : {`PEE_FLAG_W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // Event and state outputs.

  // One register stage keeps every bit a clean single-cycle pulse.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      perf_event_bus <= {`PEE_EVT_W{1'b0}};
    else
      perf_event_bus <= next_event_bus;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_unit_flags <= {`PEE_FLAG_W{1'b0}};
      secure_state_out <= 1'b0;
      privileged_mode_out <= 1'b0;
      perf_monitor_irq <= 1'b0;
    end
    else
    begin
      vector_unit_flags <= next_flags;
      secure_state_out <= core_secure;
      privileged_mode_out <= core_privileged;
      perf_monitor_irq <= core_ovf_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= pee_pkg::PH_IDLE;
      wr_addr <= 8'h00;
    end
    else if (bus_take)
    begin
      phase <= hwrite ? pee_pkg::PH_WR : pee_pkg::PH_RD;
      wr_addr <= a_mapped ? a_off : 8'hFF;
    end
    else
    begin
      phase <= pee_pkg::PH_IDLE;
    end
  end

  // Read data is caught in the address phase so no wait state is needed.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (bus_take && !hwrite)
      hrdata <= rd_word;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `PEE_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= hwdata[3:0];
  end

  // A software increment write with bit 0 set turns into exactly one event pulse.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sw_inc_req <= 1'b0;
    else
      sw_inc_req <= wr_swinc;
  end

endmodule // pee_top

/* test/pee_top_checker.sv */
// Purpose: Assertions on the event export outputs.
// Assumes: One clock; gated bits are checked only when nonzero.
// Notes: Bound to pee_top after the module.
`timescale 1ns/1ns
module pee_top_checker
(
  input logic hclk,
  input logic hresetn,
  input logic [6:0] core_mem_evt,
  input logic [1:0] core_ren_cnt,
  input logic [1:0] core_fp_ren_cnt,
  input logic [31:0] fp_status_control_reg,
  input logic core_secure,
  input logic core_privileged,
  input logic core_ovf_irq,
  input logic [51:0] perf_event_bus,
  input logic [6:0] vector_unit_flags,
  input logic perf_monitor_irq,
  input logic secure_state_out,
  input logic privileged_mode_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_lone;
    !core_mem_evt[6] ##1 core_mem_evt[6] ##1 !core_mem_evt[6];
  endsequence
  chk_mem_map: assert property (
    |perf_event_bus[7:1] |-> perf_event_bus[7:1] == $past(core_mem_evt))
    else $error("mem bits wrong");
  chk_ren_pair: assert property (
    perf_event_bus[9] |-> !perf_event_bus[8] && $past(core_ren_cnt) == 2'h2)
    else $error("rename pair wrong");
  chk_fp_pair: assert property (
    perf_event_bus[36] |-> $past(core_fp_ren_cnt) == 2'h2)
    else $error("fp pair wrong");
  chk_flag_copy: assert property (
    |vector_unit_flags |-> vector_unit_flags[5:0] ==
    {$past(fp_status_control_reg[7]), $past(fp_status_control_reg[4:0])}
    && (!vector_unit_flags[6] || $past(fp_status_control_reg[27])))
    else $error("flags wrong");
  chk_secure_copy: assert property (
    $past(hresetn) |-> secure_state_out == $past(core_secure))
    else $error("secure stale");
  chk_priv_copy: assert property (
    $past(hresetn) |-> privileged_mode_out == $past(core_privileged))
    else $error("priv stale");
  chk_irq_copy: assert property (
    $past(hresetn) |-> perf_monitor_irq == $past(core_ovf_irq))
    else $error("irq stale");
  chk_one_cycle: assert property (
    s_lone |=> !perf_event_bus[7]) else $error("event bit held");
endmodule // pee_top_checker
bind pee_top pee_top_checker pee_top_checker_i (.hclk, .hresetn,
  .core_mem_evt, .core_ren_cnt, .core_fp_ren_cnt, .fp_status_control_reg,
  .core_secure, .core_privileged, .core_ovf_irq, .perf_event_bus,
  .vector_unit_flags, .perf_monitor_irq, .secure_state_out,
  .privileged_mode_out);

/* test/pee_counter_model.sv */
// Purpose: External counter on event bit zero.
// Assumes: Events are high for one cycle each.
// Notes: Counts high cycles, so a held bit over-counts.
`timescale 1ns/1ns
module pee_counter_model
(
  input logic hclk,
  input logic hresetn,
  input logic [51:0] perf_event_bus,
  output logic [31:0] count
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 32'h0000_0000;
    else if (perf_event_bus[0])
      count <= count + 32'h0000_0001;
  end
endmodule // pee_counter_model

/* test/tb.sv */
// Purpose: Self-checking bench for the event export block.
// Assumes: Zero-wait AHB-Lite slave.
// Notes: Checks registers, flags and state, then walks every event bit and the software increment.
`timescale 1ns/1ns
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] fps = 32'h0000_0000;
  logic sec = 1'b0;
  logic priv = 1'b0;
  logic ovf = 1'b0;
  pee_pkg::pee_raw_t raw = '0;
  logic hreadyout, hresp, irq, sec_seen, priv_seen;
  logic [31:0] hrdata, rd, count;
  logic [51:0] bus;
  logic [6:0] flags;
  int err_count = 0;
  int n_checks = 0;
  always #10 hclk = ~hclk;
  pee_top pee_top_i
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .core_sw_inc(raw.sw_inc), .core_mem_evt(raw.mem),
    .core_ren_cnt(raw.ren_cnt), .core_flow_evt(raw.flow),
    .core_func_ret(raw.ret), .core_unaligned(raw.unal),
    .core_mispredict(raw.misp), .core_pred_branch(raw.pred_br),
    .core_bytecode_evt(raw.bytecode), .core_coh_miss(raw.coh_miss),
    .core_coh_hit(raw.coh_hit), .core_stall_evt(raw.stall),
    .core_pipe_evt(raw.pipe), .core_fp_ren_cnt(raw.fp_cnt),
    .core_simd_ren_cnt(raw.simd_cnt), .core_mem_stall_evt(raw.mstall),
    .core_clkoff_evt(raw.clkoff), .core_barrier_evt(raw.barrier),
    .fp_status_control_reg(fps), .core_secure(sec),
    .core_privileged(priv), .core_ovf_irq(ovf), .perf_event_bus(bus),
    .vector_unit_flags(flags), .perf_monitor_irq(irq),
    .secure_state_out(sec_seen), .privileged_mode_out(priv_seen)
  );
  pee_counter_model pee_counter_model_i
  (
    .hclk, .hresetn, .perf_event_bus(bus), .count
  );
  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_op(logic wr, logic [7:0] a, logic [3:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {28'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  // Reference map of core events onto bus bits, counts as bit pairs.
  function automatic logic [51:0] exp_bus(pee_pkg::pee_raw_t r, logic mp);
    return {r.barrier, r.clkoff, r.mstall, r.simd_cnt == 2'h2,
      r.simd_cnt == 2'h1, r.fp_cnt == 2'h2, r.fp_cnt == 2'h1, r.pipe,
      r.stall, r.coh_hit & mp, r.coh_miss & mp, r.bytecode, r.pred_br,
      r.misp, r.unal, r.ret, r.flow, r.ren_cnt == 2'h2,
      r.ren_cnt == 2'h1, r.mem, r.sw_inc};
  endfunction
  task automatic pulse(pee_pkg::pee_raw_t v, logic mp, logic en);
    @(posedge hclk);
    raw <= v;
    @(posedge hclk);
    raw <= '0;
    #1 check("event bus", bus, exp_bus(v, mp) & {52{en}});
    @(posedge hclk);
    #1 check("event gap", bus, 52'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    fps <= 32'hFFFF_FFFF;
    sec <= 1'b1;
    priv <= 1'b1;
    ovf <= 1'b1;
    bus_op(1'b0, 8'h00, 4'h0);
    check("ctrl reset", rd, 32'h0000_0001);
    bus_op(1'b0, 8'h08, 4'h0);
    check("status", rd, 32'h0000_0380);
    bus_op(1'b0, 8'h14, 4'h0);
    check("unmapped", rd, 32'h0000_0000);
    bus_op(1'b1, 8'h00, 4'hD);
    settle();
    check("fpu flags", flags, 7'h3F);
    bus_op(1'b1, 8'h00, 4'hF);
    settle();
    check("media flags", flags, 7'h7F);
    sec <= 1'b0;
    priv <= 1'b0;
    ovf <= 1'b0;
    settle();
    check("state outs", {sec_seen, priv_seen, irq}, 3'h0);
    for (int i = 0; i < 52; i++)
      pulse(52'h1 << i, 1'b1, 1'b1);
    // An illegal rename count of three must report nothing.
    pulse(52'h3 << 42, 1'b1, 1'b1);
    bus_op(1'b1, 8'h00, 4'h0);
    settle();
    check("flags off", flags, 7'h00);
    pulse('1, 1'b0, 1'b0);
    bus_op(1'b1, 8'h00, 4'h1);
    bus_op(1'b1, 8'h04, 4'h1);
    repeat (4) @(posedge hclk);
    check("sw count", count, 32'h0000_0002);
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end
endmodule // tb
